// >>> include/csb_pkg.sv
package csb_pkg;
  // Instruction selector codes presented by the decoder
  typedef enum logic [2:0] {
    op_none,
    cmp_imm_op,
    cmp_carry_op,
    skip_reg_bit_clear_op,
    skip_reg_bit_set_op,
    skip_io_bit_clear_op,
    skip_io_bit_set_op,
    branch_flag_set_op
  } op_t;

  // Status register bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;

  // Program counter steps, cycle counts, status reset value and program counter width
  localparam logic [1:0] SKIP_ONE_WORD = 2'h2;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h3;
  localparam logic [1:0] CYC_SKIP_NONE = 2'h1;
  localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
  localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int unsigned PC_WIDTH = 16;
endpackage

// >>> src/compare_skip_branch_unit.sv
`timescale 1ns/100ps
module compare_skip_branch_unit
  import csb_pkg::*;
#(
  parameter int unsigned PCW = PC_WIDTH
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Issued instruction
  input wire logic issue,
  input wire op_t op,
  input wire logic [7:0] dest_value,
  input wire logic [7:0] source_register,
  input wire logic [7:0] imm_value,
  input wire logic [7:0] io_value,
  input wire logic [2:0] bit_sel,
  input wire logic signed [6:0] br_offset,
  input wire logic next_is_two_word,
  input wire logic [PCW-1:0] pc_in,
  // Status register load from elsewhere in the core
  input wire logic status_load,
  input wire logic [7:0] status_in,
  // Results
  output logic busy,
  output logic done,
  output logic pc_load,
  output logic [PCW-1:0] pc_out,
  output logic [7:0] status_register
);
  typedef enum logic [1:0] {st_idle, st_wait} state_t;

  state_t state_r, state_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, pc_load_r, pc_load_nxt;
  logic [PCW-1:0] pc_r, pc_nxt;
  logic [7:0] status_register_r, status_register_nxt;
  logic [7:0] diff;
  logic alu_c, alu_h, alu_v, alu_n;
  logic use_carry, test_bit, is_skip, skip_hit;
  logic [1:0] step, cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Shared subtractor for both compares
  assign use_carry = (op == cmp_carry_op);
  csb_sub_alu u_alu (
    .minuend(dest_value),
    .subtrahend(use_carry ? source_register : imm_value),
    .borrow_in(use_carry & status_register_r[FLAG_C]),
    .diff(diff),
    .flag_c(alu_c),
    .flag_h(alu_h),
    .flag_v(alu_v),
    .flag_n(alu_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bit test selection and skip distance
  always_comb begin
    is_skip = (op == skip_reg_bit_clear_op) || (op == skip_reg_bit_set_op) ||
              (op == skip_io_bit_clear_op) || (op == skip_io_bit_set_op);
    test_bit = ((op == skip_io_bit_clear_op) || (op == skip_io_bit_set_op)) ? io_value[bit_sel]
                                                                           : source_register[bit_sel];
    // Clear variants skip on zero, set variants on one
    skip_hit = is_skip && (((op == skip_reg_bit_clear_op || op == skip_io_bit_clear_op) && !test_bit) ||
                           ((op == skip_reg_bit_set_op || op == skip_io_bit_set_op) && test_bit));
    step = next_is_two_word ? SKIP_TWO_WORD : SKIP_ONE_WORD;
    cycles = !skip_hit ? CYC_SKIP_NONE : (next_is_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; the result pulses when the last cycle ends
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    pc_load_nxt = 1'b0;
    pc_nxt = pc_r;
    status_register_nxt = status_load ? status_in : status_register_r;
    case (state_r)
      st_idle: begin
        if (issue) begin
          if (op == cmp_imm_op || op == cmp_carry_op) begin
            status_register_nxt[FLAG_C] = alu_c;
            status_register_nxt[FLAG_H] = alu_h;
            status_register_nxt[FLAG_V] = alu_v;
            status_register_nxt[FLAG_N] = alu_n;
            // Carry compare keeps Z cleared unless the chained result is zero too
            status_register_nxt[FLAG_Z] = use_carry ? ((diff == 8'h00) & status_register_r[FLAG_Z]) : (diff == 8'h00);
            status_register_nxt[FLAG_S] = alu_n ^ alu_v;
            done_nxt = 1'b1;
          end else if (is_skip) begin
            // Flags are left to the load path only
            pc_nxt = skip_hit ? pc_in + PCW'(step) : pc_in + PCW'(1);
            pc_load_nxt = skip_hit;
            if (cycles == CYC_SKIP_NONE) begin
              done_nxt = 1'b1;
            end else begin
              state_nxt = st_wait;
              wait_nxt = cycles - 2'h1;
              busy_nxt = 1'b1;
              pc_load_nxt = 1'b0;
            end
          end else if (op == branch_flag_set_op) begin
            if (status_register_r[bit_sel]) begin
              pc_nxt = pc_in + PCW'(signed'(br_offset)) + PCW'(1);
              state_nxt = st_wait;
              wait_nxt = CYC_BR_TAKEN - 2'h1;
              busy_nxt = 1'b1;
            end else begin
              pc_nxt = pc_in + PCW'(1);
              done_nxt = 1'b1;
            end
          end
        end
      end
      st_wait: begin
        wait_nxt = wait_r - 2'h1;
        if (wait_r == 2'h1) begin
          state_nxt = st_idle;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          pc_load_nxt = 1'b1;
        end
      end
      default: state_nxt = st_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; enable low freezes everything
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= st_idle;
      wait_r <= 2'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_r <= '0;
      status_register_r <= STATUS_RESET;
    end else if (clk_en) begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pc_load_r <= pc_load_nxt;
      pc_r <= pc_nxt;
      status_register_r <= status_register_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign pc_load = pc_load_r;
  assign pc_out = pc_r;
  assign status_register = status_register_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_skip_no_flags: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && is_skip && !status_load) |=> $stable(status_register_r))
    else $error("skip altered status");
  a_skip_two_word: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && skip_hit && next_is_two_word) |=>
      (pc_r == $past(pc_in) + PCW'(3)))
    else $error("two-word skip wrong pc");
  a_skip_one_word: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && skip_hit && !next_is_two_word) |=>
      (pc_r == $past(pc_in) + PCW'(2)))
    else $error("one-word skip wrong pc");
  // Done shows in the cycle after the third enabled edge, so the check sits one edge later
  a_skip_three_cyc: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && skip_hit && next_is_two_word) ##1 clk_en[*2] |=> done_r)
    else $error("two-word skip not three cycles");
  a_skip_no_hit: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && is_skip && !skip_hit) |=> (done_r && !pc_load_r))
    else $error("unskipped test misbehaved");
  a_io_clear_skip: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == skip_io_bit_clear_op && !io_value[bit_sel]) |=> busy_r)
    else $error("io clear test did not skip");
  a_io_set_skip: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == skip_io_bit_set_op && io_value[bit_sel]) |=> busy_r)
    else $error("io set test did not skip");
  a_cmp_single_cyc: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == cmp_imm_op) |=> (done_r && !pc_load_r && !busy_r))
    else $error("compare not single cycle");
  a_cmp_zero_flag: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == cmp_imm_op && !status_load) |=>
      (status_register_r[FLAG_Z] == ($past(dest_value) == $past(imm_value))))
    else $error("compare zero flag wrong");
  a_cmp_carry_flag: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == cmp_carry_op && !status_load) |=>
      (status_register_r[FLAG_C] == ({1'b0, $past(dest_value)} <
        {1'b0, $past(source_register)} + 9'($past(status_register_r[FLAG_C])))))
    else $error("compare carry flag wrong");
  a_branch_taken: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == branch_flag_set_op && status_register_r[bit_sel]) ##1 clk_en
      |=> (pc_load_r && done_r))
    else $error("taken branch not two cycles");
  a_branch_untaken: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == branch_flag_set_op && !status_register_r[bit_sel]) |=> (done_r && !pc_load_r))
    else $error("untaken branch wrong");
  a_branch_no_flags: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && state_r == st_idle && issue && op == branch_flag_set_op && !status_load) |=> $stable(status_register_r))
    else $error("branch altered status");

  // Main scenarios, including an offer refused while busy
  c_skip_two: cover property (@(posedge core_clk) issue && skip_hit && next_is_two_word && state_r == st_idle);
  c_skip_one: cover property (@(posedge core_clk) issue && skip_hit && !next_is_two_word && state_r == st_idle);
  c_branch: cover property (@(posedge core_clk) issue && op == branch_flag_set_op && status_register_r[bit_sel]);
  c_compare: cover property (@(posedge core_clk) issue && op == cmp_carry_op);
  c_refused: cover property (@(posedge core_clk) issue && busy_r);
endmodule // compare_skip_branch_unit

// >>> src/csb_sub_alu.sv
`timescale 1ns/100ps
// Eight-bit subtract with borrow-in, producing compare flags
module csb_sub_alu
  import csb_pkg::*;
(
  // Operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic borrow_in,
  // Results
  output logic [7:0] diff,
  output logic flag_c,
  output logic flag_h,
  output logic flag_v,
  output logic flag_n
);
  logic [8:0] full;
  logic [4:0] low;

  // Widened subtraction exposes the borrows
  always_comb begin
    full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
    diff = full[7:0];
    flag_c = full[8];
    flag_h = low[4];
    flag_n = full[7];
    flag_v = (minuend[7] & ~subtrahend[7] & ~full[7]) | (~minuend[7] & subtrahend[7] & full[7]);
  end
endmodule // csb_sub_alu

// >>> tb/tb_top.sv
`timescale 1ns/100ps
// Counts every comparison and reports a mismatch at once
`define check_eq(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module tb_top
  import csb_pkg::*;
;
  logic core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, issue = 1'b0;
  op_t op = op_none;
  logic [7:0] dest_value = 8'h00, source_register = 8'h00, imm_value = 8'h00, io_value = 8'h00;
  logic [7:0] status_in = 8'h00, status_register, exp_status = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic signed [6:0] br_offset = 7'h00;
  logic next_is_two_word = 1'b0, status_load = 1'b0, busy, done, pc_load;
  logic [15:0] pc_in = 16'h0100, pc_out;
  int fail_count = 0, compares = 0, cycles = 0;

  compare_skip_branch_unit #(.PCW(16)) i_compare_skip_branch_unit (.core_clk(core_clk), .srst(srst),
    .clk_en(clk_en), .issue(issue), .op(op), .dest_value(dest_value), .source_register(source_register),
    .imm_value(imm_value), .io_value(io_value), .bit_sel(bit_sel), .br_offset(br_offset),
    .next_is_two_word(next_is_two_word), .pc_in(pc_in), .status_load(status_load), .status_in(status_in),
    .busy(busy), .done(done), .pc_load(pc_load), .pc_out(pc_out), .status_register(status_register));

  ////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock and a hang guard well above the fewer than one hundred cycles needed
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Issues one op and measures cycles to done; a refused op rides issue while busy
  task automatic run_op(input op_t o, input logic [2:0] b, input logic two, input int exp_cyc,
                        input logic exp_load, input logic [15:0] exp_pc, input int hold, input logic refuse);
    int n;
    @(posedge core_clk);
    #1;
    issue = 1'b1;
    op = o;
    bit_sel = b;
    next_is_two_word = two;
    @(posedge core_clk);
    #1;
    n = 1;
    `check_eq("busy", (exp_cyc - hold > 1), busy)
    if (refuse) begin
      op = cmp_imm_op;
      dest_value = 8'h00;
      imm_value = 8'h01;
    end else issue = 1'b0;
    // Freeze mid-operation: the count must stretch by exactly the frozen cycles
    if (hold > 0) begin
      clk_en = 1'b0;
      repeat (hold) @(posedge core_clk);
      #1;
      clk_en = 1'b1;
      n += hold;
    end
    while (done !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    issue = 1'b0;
    `check_eq("cycles", exp_cyc, n)
    `check_eq("pc_load", exp_load, pc_load)
    if (!$isunknown(exp_pc)) `check_eq("pc_out", exp_pc, pc_out)
    `check_eq("status", exp_status, status_register)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `check_eq("busy", 1'b0, busy)
    `check_eq("done", 1'b0, done)
    `check_eq("pc_out", 16'h0000, pc_out)
    `check_eq("status", STATUS_RESET, status_register)
  endtask

  // Borrow, equality and signed overflow with half borrow, then chained carry compares
  task automatic t_compare();
    logic [7:0] d[3] = '{8'h10, 8'h35, 8'h80};
    logic [7:0] k[3] = '{8'h20, 8'h35, 8'h01};
    logic [7:0] s[3] = '{8'h15, 8'h02, 8'h38};
    for (int i = 0; i < 3; i++) begin
      dest_value = d[i];
      imm_value = k[i];
      exp_status = s[i];
      run_op(cmp_imm_op, 3'h0, 1'b0, 1, 1'b0, 16'hxxxx, 0, 1'b0);
    end
    @(posedge core_clk);
    #1;
    status_load = 1'b1;
    status_in = 8'hc3;
    @(posedge core_clk);
    #1;
    status_load = 1'b0;
    dest_value = 8'h01;
    source_register = 8'h00;
    exp_status = 8'hc2;
    run_op(cmp_carry_op, 3'h0, 1'b0, 1, 1'b0, 16'hxxxx, 0, 1'b0);
    exp_status = 8'hc0;
    run_op(cmp_carry_op, 3'h0, 1'b0, 1, 1'b0, 16'hxxxx, 0, 1'b0);
  endtask

  // Every skip op with no skip, one-word skip and two-word skip
  task automatic t_skips();
    op_t ops[4] = '{skip_reg_bit_clear_op, skip_reg_bit_set_op, skip_io_bit_clear_op, skip_io_bit_set_op};
    logic clr;
    for (int i = 0; i < 4; i++) begin
      clr = (i % 2 == 0);
      source_register = (i < 2) ? 8'h20 : 8'hdf;
      io_value = (i < 2) ? 8'hdf : 8'h20;
      for (int k = 0; k < 3; k++)
        run_op(ops[i], (k == 0) == clr ? 3'h5 : 3'h4, k != 1, k + 1, k != 0,
               16'h0100 + ((k == 0) ? 16'h1 : 16'(k + 1)), 0, 1'b0);
    end
    run_op(skip_io_bit_set_op, 3'h5, 1'b1, 5, 1'b1, 16'h0103, 2, 1'b0);
  endtask

  // Taken backwards with an op offered while busy, untaken, and largest forward offset
  task automatic t_branch();
    pc_in = 16'h0200;
    br_offset = -7'sd5;
    run_op(branch_flag_set_op, 3'h7, 1'b0, 2, 1'b1, 16'h01fc, 0, 1'b1);
    run_op(branch_flag_set_op, 3'(FLAG_Z), 1'b0, 1, 1'b0, 16'h0201, 0, 1'b0);
    br_offset = 7'sd63;
    run_op(branch_flag_set_op, 3'h6, 1'b0, 2, 1'b1, 16'h0240, 0, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset for three cycles, then the scenarios in order
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    t_reset();
    srst = 1'b0;
    t_compare();
    t_skips();
    t_branch();
    complete_run();
  end
endmodule // tb_top
